// *** inc/dcpwm_regs.svh ***
// Register addresses, field positions, reset values and counts of the
// dual channel modulator. Assumes inclusion by bare name from src files.
`ifndef DCPWM_REGS_SVH
`define DCPWM_REGS_SVH

// -----------------------------------------------------------------------
// Special-function register addresses
// -----------------------------------------------------------------------
`define DCPWM_ADDR_CTRL     8'hAE
`define DCPWM_ADDR_CH0_LOW  8'hB1
`define DCPWM_ADDR_CH0_HIGH 8'hB2
`define DCPWM_ADDR_CH1_LOW  8'hB3
`define DCPWM_ADDR_CH1_HIGH 8'hB4

// -----------------------------------------------------------------------
// Control fields and reset values
// -----------------------------------------------------------------------
`define DCPWM_MODE_MSB      6
`define DCPWM_MODE_LSB      4
`define DCPWM_DIV_MSB       3
`define DCPWM_DIV_LSB       2
`define DCPWM_SRC_MSB       1
`define DCPWM_SRC_LSB       0
`define DCPWM_CTRL_MASK     8'h7F
`define DCPWM_CTRL_RESET    8'h00
`define DCPWM_DATA_RESET    8'h00
`define DCPWM_READ_IDLE     8'h00

// -----------------------------------------------------------------------
// Counts
// -----------------------------------------------------------------------
`define DCPWM_XTAL_DIV      15
`define DCPWM_CNT_ZERO      16'h0000
`define DCPWM_CNT_LAST      16'hFFFF
`define DCPWM_BYTE_ZERO     8'h00
`define DCPWM_PRE_W         6

`endif

// *** inc/dcpwm_pkg.sv ***
// Types shared by the modulator files.
// Assumes nothing of its surroundings.
package dcpwm_pkg;

    // -------------------------------------------------------------------
    // Operating modes, coded as the mode field holds them
    // -------------------------------------------------------------------
    typedef enum logic [2:0] {
        DCPWM_MODE_OFF    = 3'b000,
        DCPWM_MODE_VAR16  = 3'b001,
        DCPWM_MODE_TWIN8  = 3'b010,
        DCPWM_MODE_TWIN16 = 3'b011,
        DCPWM_MODE_NRZ    = 3'b100,
        DCPWM_MODE_DUAL8  = 3'b101,
        DCPWM_MODE_RZ     = 3'b110,
        DCPWM_MODE_HOLD   = 3'b111
    } dcpwm_mode_t;

    // -------------------------------------------------------------------
    // Counting clock sources
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {
        DCPWM_SRC_XTAL15 = 2'b00,
        DCPWM_SRC_XTAL   = 2'b01,
        DCPWM_SRC_EXT    = 2'b10,
        DCPWM_SRC_PLL    = 2'b11
    } dcpwm_src_t;

endpackage

// *** src/dcpwm_tick_gen.sv ***
// Counting-clock tick generator: source select, crystal divide, prescale.
// Assumes crystal and PLL clock levels are synchronous to clock; the
// external pin is not and is synchronised here.
`timescale 1ns/1ps
`include "dcpwm_regs.svh"

module dcpwm_tick_gen #(
    parameter int XTAL_DIV = `DCPWM_XTAL_DIV
) (
    input  wire logic                clock,
    input  wire logic                nrst,
    input  wire logic                crystalClock,
    input  wire logic                pllClock,
    input  wire logic                extCountClockPin,
    input  wire dcpwm_pkg::dcpwm_src_t clockSource,
    input  wire logic [1:0]          clockDivider,
    input  wire logic                restart,
    output logic                     countTick
);
    import dcpwm_pkg::*;

    if (XTAL_DIV < 2 || XTAL_DIV > 16) begin : g_bad_div
        $error("XTAL_DIV must lie in 2..16");
    end

    localparam logic [3:0] XTAL_LAST = 4'(XTAL_DIV - 1);

    logic                    xtalPrev_q, pllPrev_q;
    logic                    extSync1_q, extSync2_q, extPrev_q;
    logic [3:0]              xtalCnt_q;
    logic [`DCPWM_PRE_W-1:0] preCnt_q;
    logic                    xtalEdge, pllEdge, extEdge, xtalDivTick;
    logic                    srcTick, preWrap;
    logic [`DCPWM_PRE_W-1:0] preLast;

    // -------------------------------------------------------------------
    // Edge detection; only the second sync stage is looked at
    // -------------------------------------------------------------------
    // Reset to the high level, so a source already high at release is
    // not mistaken for a fresh rising edge
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            xtalPrev_q <= 1'b1;
            pllPrev_q  <= 1'b1;
            extSync1_q <= 1'b1;
            extSync2_q <= 1'b1;
            extPrev_q  <= 1'b1;
        end else begin
            xtalPrev_q <= crystalClock;
            pllPrev_q  <= pllClock;
            extSync1_q <= extCountClockPin;
            extSync2_q <= extSync1_q;
            extPrev_q  <= extSync2_q;
        end
    end

    assign xtalEdge    = crystalClock & ~xtalPrev_q;
    assign pllEdge     = pllClock & ~pllPrev_q;
    assign extEdge     = extSync2_q & ~extPrev_q;
    assign xtalDivTick = xtalEdge && (xtalCnt_q == XTAL_LAST);

    // Source mux
    always_comb begin
        unique case (clockSource)
            DCPWM_SRC_XTAL15: srcTick = xtalDivTick;
            DCPWM_SRC_XTAL:   srcTick = xtalEdge;
            DCPWM_SRC_EXT:    srcTick = extEdge;
            DCPWM_SRC_PLL:    srcTick = pllEdge;
        endcase
    end

    // Prescaler limit 0, 3, 15 or 63
    assign preLast = `DCPWM_PRE_W'((1 << (2 * clockDivider)) - 1);
    assign preWrap = srcTick && (preCnt_q == preLast);

    // -------------------------------------------------------------------
    // Crystal divide-by-15 and prescaler; restarted by control writes
    // -------------------------------------------------------------------
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            xtalCnt_q <= 4'h0;
        end else if (restart || xtalDivTick) begin
            xtalCnt_q <= 4'h0;
        end else if (xtalEdge) begin
            xtalCnt_q <= xtalCnt_q + 4'h1;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            preCnt_q  <= '0;
            countTick <= 1'b0;
        end else if (restart) begin
            preCnt_q  <= '0;
            countTick <= 1'b0;
        end else begin
            preCnt_q  <= preWrap ? '0 : preCnt_q + `DCPWM_PRE_W'(srcTick);
            countTick <= preWrap;
        end
    end

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    property p_div_gap;
        @(posedge clock) disable iff (!nrst)
        (countTick && clockDivider != 2'b00) |=> !countTick [*3];
    endproperty
    a_div_gap: assert property (p_div_gap)
        else $error("divided tick came too soon");

    property p_pll_direct;
        @(posedge clock) disable iff (!nrst)
        (pllEdge && clockSource == DCPWM_SRC_PLL && clockDivider == 2'b00
         && !restart) |=> countTick;
    endproperty
    a_pll_direct: assert property (p_pll_direct)
        else $error("pll edge gave no tick");

    property p_ext_sync;
        @(posedge clock) disable iff (!nrst)
        extEdge |-> ($past(extCountClockPin, 2)
                     && !$past(extCountClockPin, 3));
    endproperty
    a_ext_sync: assert property (p_ext_sync)
        else $error("external edge not two stages late");

endmodule

// *** src/dcpwm_unit.sv ***
// Dual channel modulator: control and data registers on the special-
// function bus, counter and waveform logic for the eight modes.
// Assumes sfr strobes and pins synchronous to clock (except the external
// count pin) and pin muxing outside that honours the drive enables.
`timescale 1ns/1ps
`include "dcpwm_regs.svh"

// Function
// - Control bits 6..4 choose the mode: 0 off, 2 twin 8-bit, 3 twin 16-bit, 5 dual 8-bit.
// - Mode 1 gives one 16-bit output with programmable pulse and cycle length.
// - Mode 4 gives two non-return-to-zero 16-bit pulse-density bitstreams.
// - Mode 6 gives two return-to-zero pulse-density outputs, low for the second half of each high cycle.
// - Mode 7 holds the counter in reset and leaves both outputs unused.
// - Control bits 3..2 divide the counting clock by 1, 4, 16 or 64.
// - Control bits 1..0 pick crystal/15, crystal, external pin or PLL clock.
// - Every control write resets the counter besides storing the settings.
// - In 16-bit modes the low byte is written first and only held.
// - A high byte write loads high and held low together, applied from the next cycle.
// - In modes 3, 4 and 6 the two pairs set the two duties; in mode 5 pair 0 sets both duties, pair 1 both periods.
// - In mode 1 the second pair sets the period and the first the duty.
// - Mode 3 counts 65536, outputs high below their pair, both rise at rollover.
// - Mode 4 outputs are high for their value out of every 65536 clocks.
// - Mode 2: second low byte sets the period, first output falls at first low byte, second output rises at second high byte and falls at first high byte.
module dcpwm_unit #(
    parameter int XTAL_DIV = `DCPWM_XTAL_DIV
) (
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic [7:0] sfrAddr,
    input  wire logic       sfrWrite,
    input  wire logic       sfrRead,
    input  wire logic [7:0] sfrWriteData,
    output logic      [7:0] sfrReadData,
    input  wire logic       crystalClock,
    input  wire logic       pllClock,
    input  wire logic       extCountClockPin,
    output logic            outputAPin,
    output logic            outputADriveEn,
    output logic            outputBPin,
    output logic            outputBDriveEn
);
    import dcpwm_pkg::*;

    logic [7:0]  ctrl_q, hold0Low_q, hold1Low_q;
    logic [15:0] stage0_q, stage1_q, act0_q, act1_q, cnt_q;
    logic [15:0] acc0_q, acc1_q, since_q, interval_q;
    logic        levelA_q, levelB_q;
    logic [15:0] cntNext;
    logic [16:0] sd0, sd1;
    logic        ctrlWr, tick, idle, wide, cycleEnd, applyNow, firstHalf;
    logic        levelAD, levelBD;
    dcpwm_mode_t mode;
    dcpwm_src_t  srcSel;

    // Sigma-delta step: carry out is the output bit
    function automatic logic [16:0] sdStep(input logic [15:0] acc,
                                           input logic [15:0] val);
        sdStep = {1'b0, acc} + {1'b0, val};
    endfunction

    // -------------------------------------------------------------------
    // Decode
    // -------------------------------------------------------------------
    assign ctrlWr = sfrWrite && (sfrAddr == `DCPWM_ADDR_CTRL);
    assign mode   = dcpwm_mode_t'(ctrl_q[`DCPWM_MODE_MSB:`DCPWM_MODE_LSB]);
    assign srcSel = dcpwm_src_t'(ctrl_q[`DCPWM_SRC_MSB:`DCPWM_SRC_LSB]);
    assign idle   = (mode == DCPWM_MODE_OFF) || (mode == DCPWM_MODE_HOLD);
    assign wide   = (mode == DCPWM_MODE_VAR16) || (mode == DCPWM_MODE_TWIN16)
                 || (mode == DCPWM_MODE_NRZ) || (mode == DCPWM_MODE_RZ);
    assign sd0    = sdStep(acc0_q, act0_q);
    assign sd1    = sdStep(acc1_q, act1_q);

    dcpwm_tick_gen #(
        .XTAL_DIV         (XTAL_DIV)
    ) u_tick (
        .clock            (clock),
        .nrst             (nrst),
        .crystalClock     (crystalClock),
        .pllClock         (pllClock),
        .extCountClockPin (extCountClockPin),
        .clockSource      (srcSel),
        .clockDivider     (ctrl_q[`DCPWM_DIV_MSB:`DCPWM_DIV_LSB]),
        .restart          (ctrlWr),
        .countTick        (tick)
    );

    // -------------------------------------------------------------------
    // Register writes
    // -------------------------------------------------------------------
    // Control write stores settings; bit 7 is not kept
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= `DCPWM_CTRL_RESET;
        end else if (ctrlWr) begin
            ctrl_q <= sfrWriteData & `DCPWM_CTRL_MASK;
        end
    end

    // Low bytes go to a hidden holder; in 8-bit modes they are also staged at once
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            hold0Low_q <= `DCPWM_DATA_RESET;
            hold1Low_q <= `DCPWM_DATA_RESET;
            stage0_q   <= {`DCPWM_DATA_RESET, `DCPWM_DATA_RESET};
            stage1_q   <= {`DCPWM_DATA_RESET, `DCPWM_DATA_RESET};
        end else if (sfrWrite) begin
            unique case (sfrAddr)
                `DCPWM_ADDR_CH0_LOW: begin
                    hold0Low_q <= sfrWriteData;
                    if (!wide) begin
                        stage0_q[7:0] <= sfrWriteData;
                    end
                end
                `DCPWM_ADDR_CH1_LOW: begin
                    hold1Low_q <= sfrWriteData;
                    if (!wide) begin
                        stage1_q[7:0] <= sfrWriteData;
                    end
                end
                `DCPWM_ADDR_CH0_HIGH: stage0_q <= {sfrWriteData, hold0Low_q};
                `DCPWM_ADDR_CH1_HIGH: stage1_q <= {sfrWriteData, hold1Low_q};
                default: ;
            endcase
        end
    end

    // Read port; low addresses return the held byte software wrote
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sfrReadData <= `DCPWM_READ_IDLE;
        end else if (sfrRead) begin
            unique case (sfrAddr)
                `DCPWM_ADDR_CTRL:     sfrReadData <= ctrl_q;
                `DCPWM_ADDR_CH0_LOW:  sfrReadData <= hold0Low_q;
                `DCPWM_ADDR_CH0_HIGH: sfrReadData <= stage0_q[15:8];
                `DCPWM_ADDR_CH1_LOW:  sfrReadData <= hold1Low_q;
                `DCPWM_ADDR_CH1_HIGH: sfrReadData <= stage1_q[15:8];
                default:              sfrReadData <= `DCPWM_READ_IDLE;
            endcase
        end
    end

    // -------------------------------------------------------------------
    // Cycle end and counter step per mode
    // -------------------------------------------------------------------
    always_comb begin
        cntNext  = cnt_q + 16'h0001;
        cycleEnd = 1'b0;
        unique case (mode)
            DCPWM_MODE_VAR16:
                cycleEnd = (cnt_q == act1_q - 16'h0001);
            DCPWM_MODE_TWIN8:
                cycleEnd = (cnt_q[7:0] == act1_q[7:0]);
            DCPWM_MODE_DUAL8: begin
                cycleEnd = (cnt_q[7:0] == act1_q[7:0]);
                cntNext[7:0]  = cycleEnd ? `DCPWM_BYTE_ZERO
                                         : cnt_q[7:0] + 8'h01;
                cntNext[15:8] = (cnt_q[15:8] == act1_q[15:8])
                              ? `DCPWM_BYTE_ZERO : cnt_q[15:8] + 8'h01;
            end
            DCPWM_MODE_TWIN16, DCPWM_MODE_NRZ, DCPWM_MODE_RZ:
                cycleEnd = (cnt_q == `DCPWM_CNT_LAST);
            DCPWM_MODE_OFF, DCPWM_MODE_HOLD:
                cycleEnd = 1'b1;
        endcase
        if (cycleEnd && mode != DCPWM_MODE_DUAL8) begin
            cntNext = `DCPWM_CNT_ZERO;
        end
    end

    // New data only at a cycle boundary, so a running cycle finishes
    assign applyNow = ctrlWr || idle || (tick && cycleEnd);

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            act0_q <= `DCPWM_CNT_ZERO;
            act1_q <= `DCPWM_CNT_ZERO;
        end else if (applyNow) begin
            act0_q <= stage0_q;
            act1_q <= stage1_q;
        end
    end

    // Counter and accumulators; control write or idle clears them
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cnt_q  <= `DCPWM_CNT_ZERO;
            acc0_q <= `DCPWM_CNT_ZERO;
            acc1_q <= `DCPWM_CNT_ZERO;
        end else if (ctrlWr || idle) begin
            cnt_q  <= `DCPWM_CNT_ZERO;
            acc0_q <= `DCPWM_CNT_ZERO;
            acc1_q <= `DCPWM_CNT_ZERO;
        end else if (tick) begin
            cnt_q  <= cntNext;
            acc0_q <= sd0[15:0];
            acc1_q <= sd1[15:0];
        end
    end

    // -------------------------------------------------------------------
    // Output levels, evaluated once per tick
    // -------------------------------------------------------------------
    always_comb begin
        levelAD = 1'b0;
        levelBD = 1'b0;
        unique case (mode)
            DCPWM_MODE_VAR16:
                levelAD = cnt_q < act0_q;
            DCPWM_MODE_TWIN8: begin
                levelAD = cnt_q[7:0] < act0_q[7:0];
                levelBD = (cnt_q[7:0] >= act1_q[15:8])
                       && (cnt_q[7:0] < act0_q[15:8]);
            end
            DCPWM_MODE_TWIN16: begin
                levelAD = cnt_q < act0_q;
                levelBD = cnt_q < act1_q;
            end
            DCPWM_MODE_DUAL8: begin
                levelAD = cnt_q[7:0] < act0_q[7:0];
                levelBD = cnt_q[15:8] < act0_q[15:8];
            end
            DCPWM_MODE_NRZ, DCPWM_MODE_RZ: begin
                levelAD = sd0[16];
                levelBD = sd1[16];
            end
            DCPWM_MODE_OFF, DCPWM_MODE_HOLD: ;
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            levelA_q <= 1'b0;
            levelB_q <= 1'b0;
        end else if (ctrlWr || idle) begin
            levelA_q <= 1'b0;
            levelB_q <= 1'b0;
        end else if (tick) begin
            levelA_q <= levelAD;
            levelB_q <= levelBD;
        end
    end

    // Tick spacing is measured so return-to-zero can drop at half time;
    // with irregular source edges the half is only as good as the last one
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            since_q    <= `DCPWM_CNT_ZERO;
            interval_q <= `DCPWM_CNT_ZERO;
        end else if (tick) begin
            since_q    <= `DCPWM_CNT_ZERO;
            interval_q <= since_q + 16'h0001;
        end else if (since_q != `DCPWM_CNT_LAST) begin
            since_q    <= since_q + 16'h0001;
        end
    end

    assign firstHalf = since_q < {1'b0, interval_q[15:1]};

    // Pins and drive enables, all registered
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            outputAPin     <= 1'b0;
            outputBPin     <= 1'b0;
            outputADriveEn <= 1'b0;
            outputBDriveEn <= 1'b0;
        end else begin
            outputAPin     <= levelA_q && (mode != DCPWM_MODE_RZ
                                           || firstHalf);
            outputBPin     <= levelB_q && (mode != DCPWM_MODE_RZ
                                           || firstHalf);
            outputADriveEn <= !idle;
            outputBDriveEn <= !idle && mode != DCPWM_MODE_VAR16;
        end
    end

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    property p_ctrl_clear;
        @(posedge clock) disable iff (!nrst)
        ctrlWr |=> (cnt_q == `DCPWM_CNT_ZERO && acc0_q == `DCPWM_CNT_ZERO);
    endproperty
    a_ctrl_clear: assert property (p_ctrl_clear)
        else $error("control write left counter running");

    property p_hold_quiet;
        @(posedge clock) disable iff (!nrst)
        (mode == DCPWM_MODE_HOLD) [*3] |->
            (cnt_q == `DCPWM_CNT_ZERO && !outputAPin && !outputBPin
             && !outputADriveEn);
    endproperty
    a_hold_quiet: assert property (p_hold_quiet)
        else $error("hold mode not quiet");

    property p_apply_at_end;
        @(posedge clock) disable iff (!nrst)
        !$stable(act0_q) |-> $past(applyNow);
    endproperty
    a_apply_at_end: assert property (p_apply_at_end)
        else $error("data applied mid cycle");

    property p_low_hidden;
        @(posedge clock) disable iff (!nrst)
        (wide && sfrWrite && sfrAddr == `DCPWM_ADDR_CH0_LOW) |=>
            $stable(stage0_q);
    endproperty
    a_low_hidden: assert property (p_low_hidden)
        else $error("low byte applied without high byte");

    property p_twin16_level;
        @(posedge clock) disable iff (!nrst)
        (mode == DCPWM_MODE_TWIN16 && tick && !ctrlWr) |=>
            (levelA_q == $past(cnt_q < act0_q));
    endproperty
    a_twin16_level: assert property (p_twin16_level)
        else $error("twin 16-bit level wrong");

    property p_var16_wrap;
        @(posedge clock) disable iff (!nrst)
        (mode == DCPWM_MODE_VAR16 && tick && !ctrlWr
         && cnt_q == act1_q - 16'h0001) |=> cnt_q == `DCPWM_CNT_ZERO;
    endproperty
    a_var16_wrap: assert property (p_var16_wrap)
        else $error("period end missed");

    // A high bit must coincide with the accumulator wrapping round
    property p_nrz_carry;
        @(posedge clock) disable iff (!nrst)
        (mode == DCPWM_MODE_NRZ && tick && !ctrlWr) |=>
            (levelA_q == (acc0_q < $past(acc0_q)));
    endproperty
    a_nrz_carry: assert property (p_nrz_carry)
        else $error("density bit not the accumulator carry");

endmodule

// *** testbench/dcpwm_testbench.sv ***
// Self-checking bench of the dual channel modulator: registers, mode
// waveforms counted over whole periods, staged 16-bit loads and reset.
// Assumes the package and the design files are compiled ahead of it.
`timescale 1ns/1ps
`include "dcpwm_regs.svh"
module testbench;
    import dcpwm_pkg::*;
    typedef struct {
        logic [7:0]  c;
        logic [15:0] d0, d1, ha, hb, ra;
    } dcpwm_row_t;
    logic       clock, nrst, sfrWrite, sfrRead, outputAPin, outputBPin;
    logic       crystalClock, pllClock, extPin, aEn, bEn;
    logic [7:0] sfrAddr, sfrWriteData, sfrReadData;
    int         bad_count = 0, check_count = 0, cyc = 0, ha, hb, ra;
    // -------------------------------------------------------------------
    // Rows: control, pair 0, pair 1, A high, B high, A rises
    // -------------------------------------------------------------------
    // Sources tick every 4 (pll), 6 (crystal), 8 (pin), 12 (crystal/2)
    dcpwm_row_t rows [14] = '{
        '{8'h13, 16'h0003, 16'h0008, 576, 0, 48},
        '{8'h13, 16'h0001, 16'h0008, 192, 0, 48},
        '{8'h11, 16'h0001, 16'h0008, 192, 0, 32},
        '{8'h12, 16'h0001, 16'h0008, 192, 0, 24},
        '{8'h10, 16'h0001, 16'h0008, 192, 0, 16},
        '{8'h17, 16'h0001, 16'h0008, 192, 0, 12},
        '{8'h1B, 16'h0001, 16'h0008, 192, 0, 3},
        '{8'h1F, 16'h0001, 16'h0002, 768, 0, 3},
        '{8'h43, 16'h4000, 16'h8000, 384, 768, 96},
        '{8'h63, 16'h4000, 16'h4000, 192, 192, 96},
        '{8'h23, 16'h0602, 16'h0207, 384, 768, 48},
        '{8'h53, 16'h0202, 16'h0307, 384, 768, 48},
        '{8'h73, 16'h0001, 16'h0008, 0, 0, 0},
        '{8'h03, 16'h0001, 16'h0008, 0, 0, 0}
    };
    // Short crystal pre-divide keeps the slow source row brief
    dcpwm_unit #(.XTAL_DIV(2)) dcpwm_unit_inst (
        .clock(clock), .nrst(nrst), .sfrAddr(sfrAddr),
        .sfrWrite(sfrWrite), .sfrRead(sfrRead),
        .sfrWriteData(sfrWriteData), .sfrReadData(sfrReadData),
        .crystalClock(crystalClock), .pllClock(pllClock),
        .extCountClockPin(extPin), .outputAPin(outputAPin),
        .outputADriveEn(aEn), .outputBPin(outputBPin),
        .outputBDriveEn(bEn));
    initial begin
        clock = 0;
        forever #50 clock = ~clock;
    end
    // Counting sources, all slower than half the system clock
    always @(negedge clock) begin
        cyc <= cyc + 1;
        pllClock <= cyc[1];
        crystalClock <= (cyc % 6) < 3;
        extPin <= cyc[2];
    end
    // -------------------------------------------------------------------
    // Tasks
    // -------------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        sfrAddr = a;
        sfrWriteData = d;
        sfrWrite = 1;
        @(negedge clock);
        sfrWrite = 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock);
        sfrAddr = a;
        sfrRead = 1;
        @(negedge clock);
        sfrRead = 0;
        @(negedge clock);
        chk(sfrReadData, exp);
    endtask
    // Low byte first, then the high byte that applies the pair
    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(a + 8'h01, v[15:8]);
    endtask
    // Window of 1536 cycles is a whole number of every row's periods
    task automatic meas(input int settle);
        logic prev;
        repeat (settle) @(negedge clock);
        {ha, hb, ra} = '0;
        prev = outputAPin;
        repeat (1536) @(negedge clock) begin
            ha += (outputAPin === 1'b1);
            hb += (outputBPin === 1'b1);
            ra += (outputAPin === 1'b1 && prev === 1'b0);
            prev = outputAPin;
        end
    endtask
    task automatic print_verdict;
        if (bad_count == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // -------------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------------
    initial begin
        {sfrWrite, sfrRead, sfrAddr, sfrWriteData} = '0;
        nrst = 0;
        repeat (2) @(negedge clock);
        nrst = 1;
        chk({aEn, bEn, outputAPin, outputBPin}, 0);
        rd(8'hB2, 8'h00);
        foreach (rows[i]) begin
            wr16(8'hB1, rows[i].d0);
            wr16(8'hB3, rows[i].d1);
            wr(8'hAE, rows[i].c);
            meas(512);
            chk(ha, rows[i].ha);
            chk(hb, rows[i].hb);
            chk(ra, rows[i].ra);
            chk(aEn, rows[i].c[6:4] inside {[1:6]});
            chk(bEn, rows[i].c[6:4] inside {[2:6]});
        end
        // Held low byte must not act until its high byte arrives
        wr16(8'hB1, 16'h0003);
        wr16(8'hB3, 16'h0008);
        wr(8'hAE, 8'h13);
        wr(8'hB1, 8'h05);
        meas(512);
        chk(ha, 576);
        rd(8'hB1, 8'h05);
        wr(8'hB2, 8'h00);
        meas(512);
        chk(ha, 960);
        // Control write restarts the count, so the short pulse shows
        wr16(8'hB1, 16'h0003);
        wr16(8'hB3, 16'h0000);
        wr(8'hAE, 8'h33);
        meas(0);
        chk(ha, 12);
        chk(hb, 0);
        chk(ra, 1);
        // Second reset in mid-run, while mode 3 drives both pins
        nrst = 0;
        @(negedge clock);
        chk({aEn, bEn, outputAPin, outputBPin}, 0);
        nrst = 1;
        rd(8'hAE, 8'h00);
        rd(8'hB1, 8'h00);
        wr(8'hAE, 8'hFF);
        rd(8'hAE, 8'h7F);
        wr(8'hB0, 8'h5A);
        rd(8'hB0, 8'h00);
        rd(8'hB4, 8'h00);
        print_verdict();
    end
endmodule
